/* usb_regmap_defs.vh */
// Purpose: Offsets, field masks, reset values for the USB register map
// Assumes: Offsets are byte offsets inside the device address window
// Notes:   Bit 0 of every register is its most significant bit
`ifndef USB_REGMAP_DEFS_VH
`define USB_REGMAP_DEFS_VH

// ----------------------------------------------------------------------
// Region offsets
// ----------------------------------------------------------------------
`define OFF_EP_CFG_BASE 15'h0000
`define OFF_EP_CFG_LAST 15'h0070
`define OFF_EP_STRIDE 15'h0010
`define OFF_SETUP_W0 15'h0080
`define OFF_SETUP_W1 15'h0084
`define OFF_EP0_RAM 15'h0088
`define OFF_EP0_RAM_END 15'h00FF
`define OFF_DEV_ADDR 15'h0100
`define OFF_CORE_CTRL 15'h0104
`define OFF_INT_STATUS 15'h0108
`define OFF_FRAME_NUM 15'h010C
`define OFF_INT_ENABLE 15'h0110
`define OFF_BUF_READY 15'h0114
`define OFF_TEST_MODE 15'h0118
`define OFF_ERR_COUNT 15'h011C
`define OFF_PHY_ACCESS 15'h0120
`define OFF_DMA_RESET 15'h0200
`define OFF_DMA_CTRL 15'h0204
`define OFF_DMA_SRC 15'h0208
`define OFF_DMA_DST 15'h020C
`define OFF_DMA_LEN 15'h0210
`define OFF_DMA_STATUS 15'h0214
`define OFF_DATA_RAM 15'h4000
`define DATA_RAM_SPAN 15'h1FFF

// ----------------------------------------------------------------------
// Word offsets inside one endpoint block
// ----------------------------------------------------------------------
`define EPW_CFG 2'h0
`define EPW_RSVD 2'h1
`define EPW_CNT0 2'h2
`define EPW_CNT1 2'h3

// ----------------------------------------------------------------------
// Field masks, bit 0 on the left
// ----------------------------------------------------------------------
`define MASK_EP_CFG 32'hFFFF9FFF
`define MASK_BYTE_CNT 32'h000007FF
`define MASK_DEV_ADDR 32'h0000007F
`define MASK_CORE_CTRL 32'hC0000000
`define MASK_ERR_BITS 32'h38000000
`define BIT_EP_TOGGLE 4
`define BIT_EP_BUFSEL 5
`define BIT_REMOTE_WAKE 1
`define RESET_WORD 32'h00000000

`endif

/* usb_regmap.v */
// Purpose: Register space and slave-bus decode of a USB device core
// Assumes: Single-beat slave bus transfers, inputs synchronous to CLK
// Notes:   Protocol engine, PHY link and DMA sequencing sit outside
//
// What this block does
// [RULE1] PHY reset output polarity follows option
// [RULE2] Window is power of two, aligned, >=0x8000
// [RULE3] With DMA, data RAM only via DMA
// [RULE4] Without DMA, DMA registers are absent
// [RULE5] Error interrupt and counter need error option
// [RULE6] No error option: count gone, checks stay
// [RULE7] Bit 0 is MSB, bit 31 LSB
// [RULE8] Decode config, setup, EP0 RAM, DMA, data RAM
// [RULE9] USB registers from 0x100 to 0x120
// [RULE10] Writes to read-only registers are ignored
// [RULE11] Write-only registers read as zero
// [RULE12] Firmware keeps EP0 buffer inside 0x00FF
// [RULE13] Data RAM window spans 0x2000 bytes
// [RULE14] Eight endpoint blocks, 0x10 apart
// [RULE15] Block holds config, reserved, two counts
// [RULE16] Engine updates toggle and buffer-select bits
// [RULE17] Master id width is max(1, clog2 masters)
// [RULE18] Reserved words and bits read zero
`include "usb_regmap_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module usb_regmap #(
  parameter phy_reset_polarity_option = 1,
  parameter dma_present_option = 1,
  parameter error_logic_present_option = 0,
  parameter [31:0] window_base_address = 32'h80000000,
  parameter [31:0] window_top_address = 32'h80007FFF,
  parameter master_id_width_option = 1,
  parameter data_ram_words = 2048,
  parameter ep0_ram_words = 30
) (
  input wire CLK,
  input wire RST,
  input wire [0:31] SPLB_ABus,
  input wire SPLB_PAValid,
  input wire SPLB_RNW,
  input wire [0:3] SPLB_BE,
  input wire [0:31] SPLB_wrDBus,
  input wire [0:master_id_width_option-1] SPLB_masterID,
  output reg SI_addrAck,
  output reg SI_wrDAck,
  output reg SI_wrComp,
  output reg SI_rdDAck,
  output reg SI_rdComp,
  output reg [0:31] SI_rdDBus,
  input wire PE_EP_UPDATE,
  input wire [2:0] PE_EP_SEL,
  input wire PE_EP_TOGGLE,
  input wire PE_EP_BUFSEL,
  input wire PE_SETUP_WE,
  input wire [0:63] PE_SETUP_DATA,
  input wire [0:31] PE_INT_EVENTS,
  input wire [0:31] PE_FRAME,
  input wire PE_PROTO_ERR,
  input wire PE_WAKE_DONE,
  input wire DMA_RAM_EN,
  input wire DMA_RAM_WE,
  input wire [10:0] DMA_RAM_ADDR,
  input wire [0:31] DMA_RAM_WDATA,
  output reg [0:31] DMA_RAM_RDATA,
  output reg PHY_RESET_OUT,
  output reg PKT_DISCARD,
  output reg DMA_SOFT_RESET,
  output wire [0:255] EP_CONFIG_ALL,
  output reg [0:31] DEVICE_ADDRESS,
  output reg [0:31] CORE_CONTROL,
  output reg [0:31] INT_ENABLE,
  output reg [0:31] BUFFER_READY,
  output reg [0:31] TEST_MODE,
  output reg [0:31] PHY_ACCESS,
  output reg [0:31] DMA_CONTROL,
  output reg [0:31] DMA_SOURCE,
  output reg [0:31] DMA_DEST,
  output reg [0:31] DMA_LENGTH
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [0:31] ep_cfg_r [0:7];
  reg [0:31] ep_cnt0_r [0:7];
  reg [0:31] ep_cnt1_r [0:7];
  reg [0:31] ep0_ram [0:ep0_ram_words-1];
  reg [0:31] data_ram [0:data_ram_words-1];
  reg [0:31] setup0_r, setup1_r;
  reg [0:31] int_status_r, frame_r;
  reg [0:31] err_count_r, dma_status_r;
  reg [0:31] rd_nxt;
  reg ack_r;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire [31:0] win_mask = window_top_address - window_base_address;
  wire [31:0] bus_addr = SPLB_ABus;
  wire in_window =
    ((bus_addr ^ window_base_address) & ~win_mask) == 32'h00000000;
  wire take = SPLB_PAValid & in_window & ~ack_r; // see [RULE2]
  wire [14:0] off = SPLB_ABus[17:31];
  wire do_wr = take & ~SPLB_RNW;
  wire do_rd = take & SPLB_RNW;
  wire [0:31] be_mask = {{8{SPLB_BE[0]}}, {8{SPLB_BE[1]}},
                         {8{SPLB_BE[2]}}, {8{SPLB_BE[3]}}};
  wire is_ep_blk = off <= (`OFF_EP_CFG_LAST + 15'h000C); // see [RULE14]
  wire [2:0] ep_idx = off[6:4];
  wire [1:0] ep_word = off[3:2];
  wire is_ep0_ram = (off >= `OFF_EP0_RAM) &&
                    (off <= `OFF_EP0_RAM_END); // see [RULE8]
  wire [14:0] ep0_byte = off - `OFF_EP0_RAM;
  wire [4:0] ep0_idx = ep0_byte[6:2];
  wire is_data_ram = (off >= `OFF_DATA_RAM) &&
                     (off <= `OFF_DATA_RAM + `DATA_RAM_SPAN); // see [RULE13]
  wire [10:0] data_idx = off[12:2];
  wire dma_on = (dma_present_option != 0);
  wire err_on = (error_logic_present_option != 0);
  wire slave_ram_ok = is_data_ram & ~dma_on; // see [RULE3]

  // Merge write data into a field under byte enables and field mask
  function [0:31] merge;
    input [0:31] old;
    input [0:31] wd;
    input [0:31] bm;
    input [0:31] fm;
    begin
      merge = ((old & ~bm) | (wd & bm)) & fm; // see [RULE18]
    end
  endfunction

  // --------------------------------------------------------------------
  // Endpoint blocks
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : ep_blk
      wire hit = do_wr & is_ep_blk & (ep_idx == g);
      always @(posedge CLK) begin
        if (RST) begin
          ep_cfg_r[g] <= `RESET_WORD;
          ep_cnt0_r[g] <= `RESET_WORD;
          ep_cnt1_r[g] <= `RESET_WORD;
        end else begin
          if (hit && ep_word == `EPW_CFG) begin
            ep_cfg_r[g] <= merge(ep_cfg_r[g], SPLB_wrDBus, be_mask,
                                 `MASK_EP_CFG); // see [RULE15]
          end else if (PE_EP_UPDATE && PE_EP_SEL == g) begin
            ep_cfg_r[g][`BIT_EP_TOGGLE] <= PE_EP_TOGGLE; // see [RULE16]
            ep_cfg_r[g][`BIT_EP_BUFSEL] <= PE_EP_BUFSEL; // see [RULE16]
          end
          if (hit && ep_word == `EPW_CNT0)
            ep_cnt0_r[g] <= merge(ep_cnt0_r[g], SPLB_wrDBus, be_mask,
                                  `MASK_BYTE_CNT); // see [RULE15]
          if (hit && ep_word == `EPW_CNT1)
            ep_cnt1_r[g] <= merge(ep_cnt1_r[g], SPLB_wrDBus, be_mask,
                                  `MASK_BYTE_CNT); // see [RULE15]
        end
      end
      assign EP_CONFIG_ALL[g*32 +: 32] = ep_cfg_r[g];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Buffer RAMs
  // --------------------------------------------------------------------
  always @(posedge CLK) begin
    if (do_wr && is_ep0_ram)
      ep0_ram[ep0_idx] <= merge(ep0_ram[ep0_idx], SPLB_wrDBus, be_mask,
                                32'hFFFFFFFF);
  end

  // One port: the DMA side owns it when DMA is built in
  wire ram_we = dma_on ? (DMA_RAM_EN & DMA_RAM_WE)
                       : (do_wr & slave_ram_ok); // see [RULE3]
  wire [10:0] ram_addr = dma_on ? DMA_RAM_ADDR : data_idx;
  wire [0:31] ram_wd = dma_on ? DMA_RAM_WDATA
                              : merge(data_ram[data_idx], SPLB_wrDBus,
                                      be_mask, 32'hFFFFFFFF);

  always @(posedge CLK) begin
    if (ram_we)
      data_ram[ram_addr] <= ram_wd;
  end

  always @(posedge CLK) begin
    if (RST || !dma_on)
      DMA_RAM_RDATA <= `RESET_WORD;
    else if (DMA_RAM_EN && !DMA_RAM_WE)
      DMA_RAM_RDATA <= data_ram[DMA_RAM_ADDR];
  end

  // --------------------------------------------------------------------
  // USB and DMA registers
  // --------------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      DEVICE_ADDRESS <= `RESET_WORD;
      CORE_CONTROL <= `RESET_WORD;
      INT_ENABLE <= `RESET_WORD;
      BUFFER_READY <= `RESET_WORD;
      TEST_MODE <= `RESET_WORD;
      PHY_ACCESS <= `RESET_WORD;
      DMA_CONTROL <= `RESET_WORD;
      DMA_SOURCE <= `RESET_WORD;
      DMA_DEST <= `RESET_WORD;
      DMA_LENGTH <= `RESET_WORD;
      dma_status_r <= `RESET_WORD;
      DMA_SOFT_RESET <= 1'b0;
    end else begin
      DMA_SOFT_RESET <= do_wr & dma_on & (off == `OFF_DMA_RESET);
      // Wake completion clears the request; a control write wins
      if (PE_WAKE_DONE)
        CORE_CONTROL[`BIT_REMOTE_WAKE] <= 1'b0;
      if (do_wr) begin
        case (off) // see [RULE9]
          `OFF_DEV_ADDR:
            DEVICE_ADDRESS <= merge(DEVICE_ADDRESS, SPLB_wrDBus, be_mask,
                                    `MASK_DEV_ADDR);
          `OFF_CORE_CTRL:
            CORE_CONTROL <= merge(CORE_CONTROL, SPLB_wrDBus, be_mask,
                                  `MASK_CORE_CTRL);
          `OFF_INT_ENABLE:
            INT_ENABLE <= merge(INT_ENABLE, SPLB_wrDBus, be_mask,
                                32'hFFFFFFFF);
          `OFF_BUF_READY:
            BUFFER_READY <= merge(BUFFER_READY, SPLB_wrDBus, be_mask,
                                  32'hFFFFFFFF);
          `OFF_TEST_MODE:
            TEST_MODE <= merge(TEST_MODE, SPLB_wrDBus, be_mask,
                               32'hFFFFFFFF);
          `OFF_PHY_ACCESS:
            PHY_ACCESS <= merge(PHY_ACCESS, SPLB_wrDBus, be_mask,
                                32'hFFFFFFFF);
          default: ;
        endcase
        if (dma_on) begin // see [RULE4]
          case (off)
            `OFF_DMA_CTRL:
              DMA_CONTROL <= merge(DMA_CONTROL, SPLB_wrDBus, be_mask,
                                   32'hFFFFFFFF);
            `OFF_DMA_SRC:
              DMA_SOURCE <= merge(DMA_SOURCE, SPLB_wrDBus, be_mask,
                                  32'hFFFFFFFF);
            `OFF_DMA_DST:
              DMA_DEST <= merge(DMA_DEST, SPLB_wrDBus, be_mask,
                                32'hFFFFFFFF);
            `OFF_DMA_LEN:
              DMA_LENGTH <= merge(DMA_LENGTH, SPLB_wrDBus, be_mask,
                                  32'hFFFFFFFF);
            `OFF_DMA_STATUS:
              dma_status_r <= merge(dma_status_r, SPLB_wrDBus, be_mask,
                                    32'hFFFFFFFF);
            default: ;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read-only state fed by the protocol engine
  // --------------------------------------------------------------------
  wire [0:31] ev_mask = err_on ? 32'hFFFFFFFF
                               : ~`MASK_ERR_BITS; // see [RULE5]
  wire isr_read = do_rd & (off == `OFF_INT_STATUS);

  always @(posedge CLK) begin
    if (RST) begin
      setup0_r <= `RESET_WORD;
      setup1_r <= `RESET_WORD;
      int_status_r <= `RESET_WORD;
      frame_r <= `RESET_WORD;
      err_count_r <= `RESET_WORD;
      PKT_DISCARD <= 1'b0;
    end else begin
      // Bus writes never reach these registers; see [RULE10]
      if (PE_SETUP_WE) begin
        setup0_r <= PE_SETUP_DATA[0:31];
        setup1_r <= PE_SETUP_DATA[32:63];
      end
      frame_r <= PE_FRAME;
      // Cleared by read, a same-cycle event still sets
      int_status_r <= ((isr_read ? `RESET_WORD : int_status_r) |
                       (PE_INT_EVENTS & ev_mask)) & 32'h7FFFFEFF;
      if (err_on && PE_PROTO_ERR) begin
        err_count_r <= err_count_r + 32'h00000001; // see [RULE5]
      end
      PKT_DISCARD <= PE_PROTO_ERR; // see [RULE6]
    end
  end

  // --------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------
  always @* begin
    rd_nxt = `RESET_WORD;
    if (is_ep_blk) begin
      case (ep_word)
        `EPW_CFG: rd_nxt = ep_cfg_r[ep_idx];
        `EPW_CNT0: rd_nxt = ep_cnt0_r[ep_idx];
        `EPW_CNT1: rd_nxt = ep_cnt1_r[ep_idx];
        default: rd_nxt = `RESET_WORD; // see [RULE18]
      endcase
    end else if (is_ep0_ram) begin
      rd_nxt = ep0_ram[ep0_idx];
    end else if (slave_ram_ok) begin
      rd_nxt = data_ram[data_idx];
    end else begin
      case (off)
        `OFF_SETUP_W0: rd_nxt = setup0_r;
        `OFF_SETUP_W1: rd_nxt = setup1_r;
        `OFF_DEV_ADDR: rd_nxt = DEVICE_ADDRESS;
        `OFF_CORE_CTRL: rd_nxt = CORE_CONTROL;
        `OFF_INT_STATUS: rd_nxt = int_status_r;
        `OFF_FRAME_NUM: rd_nxt = frame_r;
        `OFF_INT_ENABLE: rd_nxt = INT_ENABLE;
        `OFF_BUF_READY: rd_nxt = BUFFER_READY;
        `OFF_TEST_MODE: rd_nxt = TEST_MODE;
        `OFF_ERR_COUNT: rd_nxt = err_on ? err_count_r
                                        : `RESET_WORD; // see [RULE6]
        `OFF_PHY_ACCESS: rd_nxt = PHY_ACCESS;
        `OFF_DMA_RESET: rd_nxt = `RESET_WORD; // see [RULE11]
        `OFF_DMA_CTRL: rd_nxt = dma_on ? DMA_CONTROL : `RESET_WORD;
        `OFF_DMA_SRC: rd_nxt = dma_on ? DMA_SOURCE : `RESET_WORD;
        `OFF_DMA_DST: rd_nxt = dma_on ? DMA_DEST : `RESET_WORD;
        `OFF_DMA_LEN: rd_nxt = dma_on ? DMA_LENGTH : `RESET_WORD;
        `OFF_DMA_STATUS: rd_nxt = dma_on ? dma_status_r : `RESET_WORD;
        default: rd_nxt = `RESET_WORD;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Slave answer and PHY reset
  // --------------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      ack_r <= 1'b0;
      SI_addrAck <= 1'b0;
      SI_wrDAck <= 1'b0;
      SI_wrComp <= 1'b0;
      SI_rdDAck <= 1'b0;
      SI_rdComp <= 1'b0;
      SI_rdDBus <= `RESET_WORD;
    end else begin
      ack_r <= take;
      SI_addrAck <= take;
      SI_wrDAck <= do_wr;
      SI_wrComp <= do_wr;
      SI_rdDAck <= do_rd;
      SI_rdComp <= do_rd;
      SI_rdDBus <= do_rd ? rd_nxt : `RESET_WORD; // see [RULE7]
    end
  end

  always @(posedge CLK) begin
    PHY_RESET_OUT <= (phy_reset_polarity_option == 1) ? RST
                                                      : ~RST; // see [RULE1]
  end

endmodule // usb_regmap

`default_nettype wire

/* usb_regmap_properties.sv */
// Purpose: Port checks for the USB register map
// Assumes: Window of 0x8000 bytes, single-beat slave transfers
// Notes:   Bound to every usb_regmap instance
`timescale 1ns/100ps
`default_nettype none
module usb_regmap_properties #(
  parameter phy_reset_polarity_option = 1,
  parameter dma_present_option = 1,
  parameter error_logic_present_option = 0,
  parameter [31:0] window_base_address = 32'h80000000
) (
  input wire CLK,
  input wire RST,
  input wire [0:31] SPLB_ABus,
  input wire SPLB_PAValid,
  input wire SPLB_RNW,
  input wire SI_addrAck,
  input wire SI_wrDAck,
  input wire SI_rdDAck,
  input wire SI_rdComp,
  input wire [0:31] SI_rdDBus,
  input wire PE_PROTO_ERR,
  input wire PE_EP_UPDATE,
  input wire [2:0] PE_EP_SEL,
  input wire PE_EP_TOGGLE,
  input wire PKT_DISCARD,
  input wire PHY_RESET_OUT,
  input wire [0:255] EP_CONFIG_ALL
);
  // ------------------------------------------------------------------
  // Decode helpers and properties
  // ------------------------------------------------------------------
  wire in_win = SPLB_ABus[0:16] == window_base_address[31:15];
  wire taken = SPLB_PAValid && in_win && !SI_addrAck;
  wire rd_at = taken && SPLB_RNW;
  wire [14:0] off = SPLB_ABus[17:31];
  wire pol = phy_reset_polarity_option != 0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  addr_ack_due_a: assert property (taken |=> SI_addrAck)
    else $error("request in window not acknowledged");
  outside_silent_a: assert property (
    SPLB_PAValid && !in_win && !SI_addrAck |=> !SI_addrAck)
    else $error("outside request acked");
  read_pair_a: assert property (
    rd_at |=> SI_rdDAck && SI_rdComp && !SI_wrDAck)
    else $error("read answer signals wrong");
  wo_read_zero_a: assert property (
    rd_at && off == 15'h0200 |=> SI_rdDBus == 32'h0)
    else $error("write-only read not zero");
  ram_denied_a: assert property (
    rd_at && off[14:13] == 2'b10 && dma_present_option != 0
    |=> SI_rdDBus == 32'h0)
    else $error("data RAM readable over slave bus");
  err_cnt_gone_a: assert property (
    rd_at && off == 15'h011C && error_logic_present_option == 0
    |=> SI_rdDBus == 32'h0)
    else $error("error count present without option");
  rsvd_word_zero_a: assert property (
    rd_at && off[14:7] == 8'h0 && off[3:2] == 2'b01
    |=> SI_rdDBus == 32'h0)
    else $error("reserved endpoint word not zero");
  discard_follow_a: assert property (
    PKT_DISCARD == $past(PE_PROTO_ERR))
    else $error("discard pulse does not follow error");
  engine_upd_a: assert property (
    PE_EP_UPDATE && !SPLB_PAValid |=>
    EP_CONFIG_ALL[$past(PE_EP_SEL) * 32 + 4] == $past(PE_EP_TOGGLE))
    else $error("engine toggle update lost");
  phy_reset_lvl_a: assert property (
    PHY_RESET_OUT == ($past(RST) ~^ pol))
    else $error("PHY reset level wrong");
endmodule // usb_regmap_properties
bind usb_regmap usb_regmap_properties #(
  .phy_reset_polarity_option(phy_reset_polarity_option),
  .dma_present_option(dma_present_option),
  .error_logic_present_option(error_logic_present_option),
  .window_base_address(window_base_address)
) u_props (.CLK(CLK), .RST(RST), .SPLB_ABus(SPLB_ABus),
  .SPLB_PAValid(SPLB_PAValid), .SPLB_RNW(SPLB_RNW), .SI_addrAck(SI_addrAck),
  .SI_wrDAck(SI_wrDAck), .SI_rdDAck(SI_rdDAck), .SI_rdComp(SI_rdComp),
  .SI_rdDBus(SI_rdDBus), .PE_PROTO_ERR(PE_PROTO_ERR),
  .PE_EP_UPDATE(PE_EP_UPDATE), .PE_EP_SEL(PE_EP_SEL),
  .PE_EP_TOGGLE(PE_EP_TOGGLE), .PKT_DISCARD(PKT_DISCARD),
  .PHY_RESET_OUT(PHY_RESET_OUT), .EP_CONFIG_ALL(EP_CONFIG_ALL));
`default_nettype wire

/* bus_master_model.sv */
// Purpose: Slave-bus master issuing single-beat transfers
// Assumes: Request held until address acknowledge is sampled, for at most six cycles
// Notes:   Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input wire logic CLK,
  output logic [0:31] SPLB_ABus,
  output logic SPLB_PAValid,
  output logic SPLB_RNW,
  output logic [0:3] SPLB_BE,
  output logic [0:31] SPLB_wrDBus,
  input wire logic SI_addrAck,
  input wire logic [0:31] SI_rdDBus
);
  // ------------------------------------------------------------------
  // Transfer task
  // ------------------------------------------------------------------
  initial begin
    {SPLB_PAValid, SPLB_RNW, SPLB_BE} = 6'h00;
    {SPLB_ABus, SPLB_wrDBus} = 64'h0;
  end
  task automatic xfer(input logic rnw, input logic [31:0] a,
      input logic [3:0] be, input logic [31:0] wd,
      output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge CLK);
    SPLB_PAValid <= 1'b1;
    SPLB_RNW <= rnw;
    SPLB_ABus <= a;
    SPLB_BE <= be;
    SPLB_wrDBus <= wd;
    for (n = 0; n < 6 && !ok; n++) begin
      @(posedge CLK);
      if (SI_addrAck === 1'b1) begin
        ok = 1'b1;
        rd = SI_rdDBus;
      end
    end
    SPLB_PAValid <= 1'b0;
    SPLB_ABus <= ~a;
    SPLB_wrDBus <= ~wd;
  endtask
endmodule // bus_master_model
`default_nettype wire

/* usb_regmap_test.sv */
// Purpose: Self-checking bench for the USB register map
// Assumes: Default options: DMA in, error logic out, active-high PHY reset
// Notes:   Random data from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module usb_regmap_test;
  // ------------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------------
  localparam logic [31:0] base_addr = 32'h80000000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ep_upd, ep_tgl, ep_bsel, setup_we, proto_err, wake_done;
  logic dma_en, dma_we;
  logic [2:0] ep_sel;
  logic [10:0] dma_addr;
  logic [0:31] dma_wdata, frame, events;
  logic [0:63] setup_data;
  wire [0:31] abus, wdbus, rdbus, dma_rdata, core_ctrl, dma_src;
  wire [0:3] be;
  wire pav, rnw, addr_ack, phy_rst, discard, dma_rst;
  int bad_count = 0;
  int compares = 0;
  int k;
  logic [31:0] rdv, d, fr, s0, s1, ev, seed;
  logic okv;
  logic [14:0] offs [18] = '{15'h0000, 15'h0008, 15'h000C, 15'h0070,
    15'h007C, 15'h0100, 15'h0104, 15'h0110, 15'h0114, 15'h0118, 15'h0120,
    15'h0204, 15'h0208, 15'h020C, 15'h0210, 15'h0214,
    15'h0088, 15'h00FC};
  logic [14:0] ro_offs [5] = '{15'h0080, 15'h0084, 15'h0108, 15'h010C,
    15'h011C};
  always #20 clk = ~clk;
  usb_regmap #(.phy_reset_polarity_option(1), .dma_present_option(1),
    .error_logic_present_option(0),
    .window_base_address(32'h80000000)) i_dut (
    .CLK(clk), .RST(rst), .SPLB_ABus(abus), .SPLB_PAValid(pav),
    .SPLB_RNW(rnw), .SPLB_BE(be), .SPLB_wrDBus(wdbus), .SPLB_masterID(1'b0),
    .SI_addrAck(addr_ack), .SI_wrDAck(), .SI_wrComp(), .SI_rdDAck(),
    .SI_rdComp(), .SI_rdDBus(rdbus), .PE_EP_UPDATE(ep_upd),
    .PE_EP_SEL(ep_sel), .PE_EP_TOGGLE(ep_tgl), .PE_EP_BUFSEL(ep_bsel),
    .PE_SETUP_WE(setup_we), .PE_SETUP_DATA(setup_data),
    .PE_INT_EVENTS(events), .PE_FRAME(frame), .PE_PROTO_ERR(proto_err),
    .PE_WAKE_DONE(wake_done), .DMA_RAM_EN(dma_en), .DMA_RAM_WE(dma_we),
    .DMA_RAM_ADDR(dma_addr), .DMA_RAM_WDATA(dma_wdata),
    .DMA_RAM_RDATA(dma_rdata), .PHY_RESET_OUT(phy_rst),
    .PKT_DISCARD(discard), .DMA_SOFT_RESET(dma_rst), .EP_CONFIG_ALL(),
    .DEVICE_ADDRESS(), .CORE_CONTROL(core_ctrl), .INT_ENABLE(),
    .BUFFER_READY(), .TEST_MODE(), .PHY_ACCESS(), .DMA_CONTROL(),
    .DMA_SOURCE(dma_src), .DMA_DEST(), .DMA_LENGTH());
  bus_master_model i_bus (.CLK(clk), .SPLB_ABus(abus), .SPLB_PAValid(pav),
    .SPLB_RNW(rnw), .SPLB_BE(be), .SPLB_wrDBus(wdbus),
    .SI_addrAck(addr_ack), .SI_rdDBus(rdbus));
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(input logic rnw, input logic [14:0] o,
      input logic [31:0] v);
    i_bus.xfer(rnw, base_addr | 32'(o), 4'hF, v, rdv, okv);
    if (okv !== 1'b1) begin
      check("ack", 32'h0, 32'h1);
      summarize();
    end
  endtask
  task automatic rd(input logic [14:0] o, input logic [31:0] e,
      input string w);
    acc(1'b1, o, 32'h0);
    check(w, rdv, e);
  endtask
  function automatic logic [31:0] mask_of(input logic [14:0] o);
    if (o < 15'h0080)
      return (o[3:2] == 2'b00) ? 32'hFFFF9FFF : 32'h000007FF;
    if (o == 15'h0100)
      return 32'h0000007F;
    if (o == 15'h0104)
      return 32'hC0000000;
    return 32'hFFFFFFFF;
  endfunction
  initial begin
    {ep_upd, ep_tgl, ep_bsel, setup_we, proto_err, wake_done} = 6'h00;
    {dma_en, dma_we, ep_sel, dma_addr} = 16'h0000;
    {dma_wdata, frame, events, setup_data} = 160'h0;
    seed = $urandom(32'h4338);
    repeat (6) @(posedge clk);
    check("phy rst on", phy_rst, 32'h1);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("phy rst off", phy_rst, 32'h0);
    for (k = 0; k < 16; k++) rd(offs[k], 32'h0, "reset");
    foreach (offs[j]) begin
      d = $urandom;
      acc(1'b0, offs[j], d);
      rd(offs[j], d & mask_of(offs[j]), "rw");
    end
    acc(1'b0, 15'h0104, 32'h80000000);
    check("msb", core_ctrl[0], 32'h1);
    acc(1'b0, 15'h0104, 32'hC0000000);
    wake_done <= 1'b1;
    @(posedge clk) wake_done <= 1'b0;
    rd(15'h0104, 32'h80000000, "wake");
    acc(1'b0, 15'h0208, 32'h0);
    i_bus.xfer(1'b0, base_addr | 32'h208, 4'h8, 32'h11223344, rdv, okv);
    check("byte lane", dma_src, 32'h11000000);
    fr = $urandom;
    s0 = $urandom;
    s1 = $urandom;
    ev = $urandom;
    @(posedge clk);
    frame <= fr;
    setup_data <= {s0, s1};
    setup_we <= 1'b1;
    events <= ev;
    @(posedge clk);
    setup_we <= 1'b0;
    events <= 32'h0;
    foreach (ro_offs[j]) acc(1'b0, ro_offs[j], 32'hFFFFFFFF);
    rd(15'h0080, s0, "setup0");
    rd(15'h0084, s1, "setup1");
    rd(15'h010C, fr, "frame");
    rd(15'h011C, 32'h0, "errcnt");
    rd(15'h0108, ev & 32'h47FFFEFF, "isr");
    rd(15'h0108, 32'h0, "isr clear");
    d = $urandom;
    acc(1'b0, 15'h0200, d);
    check("dma soft reset", dma_rst, 32'h1);
    rd(15'h0200, 32'h0, "wo");
    acc(1'b0, 15'h4000, d);
    rd(15'h4000, 32'h0, "ram low");
    rd(15'h5FFC, 32'h0, "ram top");
    @(posedge clk);
    {dma_en, dma_we, dma_addr} <= {2'b11, 11'h7FF};
    dma_wdata <= d;
    @(posedge clk) dma_we <= 1'b0;
    @(posedge clk) dma_en <= 1'b0;
    @(posedge clk) check("dma ram", dma_rdata, d);
    for (k = 0; k < 8; k++) begin
      acc(1'b0, 15'(k * 16 + 4), 32'hFFFFFFFF);
      rd(15'(k * 16 + 4), 32'h0, "rsvd word");
    end
    acc(1'b0, 15'h0124, 32'hFFFFFFFF);
    rd(15'h0124, 32'h0, "unmapped");
    d = $urandom_range(7, 0);
    acc(1'b0, 15'(d * 16), 32'h0);
    {ep_upd, ep_sel, ep_tgl, ep_bsel} <= {1'b1, d[2:0], 2'b11};
    @(posedge clk) ep_upd <= 1'b0;
    rd(15'(d * 16), 32'h0C000000, "engine");
    proto_err <= 1'b1;
    @(posedge clk) proto_err <= 1'b0;
    @(posedge clk) check("discard", discard, 32'h1);
    i_bus.xfer(1'b1, base_addr + 32'h8000, 4'hF, 32'h0, rdv, okv);
    check("outside", okv, 32'h0);
    rd(15'h0300, 32'h0, "after");
    summarize();
  end
endmodule // usb_regmap_test
`default_nettype wire
